// ---- ssel_params.svh ----
// constants for the setting source selector
`ifndef SSEL_PARAMS_SVH
`define SSEL_PARAMS_SVH

`define SSEL_ENTRIES 16
`define SSEL_AW 12
`define SSEL_DW 8
`define SSEL_SPD_W 16

`define SSEL_ADDR_SPD_DISP 12'h1E0
`define SSEL_ADDR_SET_VIEW 12'h870
`define SSEL_ADDR_ST_SRC 12'h871
`define SSEL_ADDR_RAMP_SRC 12'h872
`define SSEL_ADDR_PANEL_VIEW 12'h874
`define SSEL_ADDR_STATUS 12'h880

`define SSEL_RST_SPD_DISP 8'h00
`define SSEL_RST_SET_VIEW 8'h00
`define SSEL_RST_ST_SRC 8'h01
`define SSEL_RST_RAMP_SRC 8'h01
`define SSEL_RST_PANEL_VIEW 8'h00

`define SSEL_MAX_SPD_DISP 8'h02
`define SSEL_MAX_VIEW 8'h05
`define SSEL_MAX_ST_SRC 8'h02
`define SSEL_MAX_RAMP_SRC 8'h01

`define SSEL_DISP_PLUS 8'h00
`define SSEL_DISP_ABS 8'h01
`define SSEL_DISP_MINUS 8'h02

`define SSEL_ST_DIGITAL 2'h0
`define SSEL_ST_ANALOG 2'h1
`define SSEL_ST_TORQUE 2'h2
`define SSEL_RAMP_ANALOG 1'h1

`define SSEL_ENTRY_POT 0
`define SSEL_ENTRY_EXT 1

`define SSEL_STAT_ACT_LSB 0
`define SSEL_STAT_ACT_MSB 1
`define SSEL_STAT_POS_BIT 2
`define SSEL_STAT_PEND_BIT 3

`endif

// ---- ssel_pkg.sv ----
// types for the setting source selector
`default_nettype none
`include "ssel_params.svh"

package ssel_pkg;

  typedef enum logic [1:0] {
    SSEL_SRC_DIGITAL = 2'h0,
    SSEL_SRC_INT_POT = 2'h1,
    SSEL_SRC_EXT = 2'h2
  } ssel_speed_src_t;

  typedef enum logic {
    SSEL_PH_SAMPLE = 1'b0,
    SSEL_PH_RUN = 1'b1
  } ssel_phase_t;

  typedef logic [`SSEL_ENTRIES-1:0][1:0] ssel_speed_vec_t;

  typedef struct packed {
    ssel_phase_t phase;
    logic [`SSEL_DW-1:0] spd_disp;
    logic [`SSEL_DW-1:0] set_view;
    logic [`SSEL_DW-1:0] st_stored;
    logic [`SSEL_DW-1:0] ramp_src;
    logic [`SSEL_DW-1:0] panel_view;
    logic [1:0] st_active;
    ssel_speed_vec_t speed_src;
    logic [`SSEL_ENTRIES-1:0] torque_ext;
    logic [`SSEL_ENTRIES-1:0] accel_pot;
    logic [`SSEL_ENTRIES-1:0] decel_pot;
    logic signed [`SSEL_SPD_W-1:0] disp_value;
    logic disp_neg;
    logic disp_sign_on;
    logic [`SSEL_DW-1:0] rdata;
  } ssel_state_t;

endpackage
`default_nettype wire

// ---- ssel_source_map.sv ----
// per-entry source decode for speed, torque and ramp times
`timescale 1ns/1ps
`default_nettype none
`include "ssel_params.svh"

module ssel_source_map
#(
  parameter int ENTRIES = `SSEL_ENTRIES
)
(
  input wire logic pos_mode_in,
  input wire logic [1:0] st_sel_in,
  input wire logic ramp_sel_in,
  output logic [ENTRIES-1:0][1:0] speed_src_out,
  output logic [ENTRIES-1:0] torque_ext_out,
  output logic [ENTRIES-1:0] accel_pot_out,
  output logic [ENTRIES-1:0] decel_pot_out
);
  import ssel_pkg::*;

  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++)
    begin : g_entry
      always_comb
      begin
        speed_src_out[g] = SSEL_SRC_DIGITAL;
        torque_ext_out[g] = 1'b0;
        accel_pot_out[g] = 1'b0;
        decel_pot_out[g] = 1'b0;
        if (!pos_mode_in)
        begin
          // speed control mode
          if (st_sel_in == `SSEL_ST_ANALOG)
          begin
            if (g == `SSEL_ENTRY_POT)
              speed_src_out[g] = SSEL_SRC_INT_POT;
            else if (g == `SSEL_ENTRY_EXT)
              speed_src_out[g] = SSEL_SRC_EXT;
          end
          else if (st_sel_in == `SSEL_ST_TORQUE)
            torque_ext_out[g] = 1'b1;
          if (ramp_sel_in == `SSEL_RAMP_ANALOG && (g == `SSEL_ENTRY_POT || g == `SSEL_ENTRY_EXT))
          begin
            accel_pot_out[g] = 1'b1;
            decel_pot_out[g] = 1'b1;
          end
        end
        else
        begin
          // position mode: speeds digital, ramp selection ignored
          if (st_sel_in == `SSEL_ST_TORQUE)
            torque_ext_out[g] = 1'b1;
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ---- ssel_top.sv ----
// common-parameter register bank and setting source selector
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ssel_params.svh"

module ssel_top
#(
  parameter int ENTRIES = `SSEL_ENTRIES,
  parameter int SPD_W = `SSEL_SPD_W
)
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [`SSEL_AW-1:0] addr_in,
  input wire logic [`SSEL_DW-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [`SSEL_DW-1:0] rdata_out,
  input wire logic pos_mode_in,
  input wire logic reload_in,
  input wire logic signed [SPD_W-1:0] speed_mon_in,
  output logic signed [SPD_W-1:0] disp_value_out,
  output logic disp_neg_out,
  output logic disp_sign_on_out,
  output logic [`SSEL_DW-1:0] setter_view_out,
  output logic [`SSEL_DW-1:0] panel_view_out,
  output logic [1:0] st_active_out,
  output ssel_pkg::ssel_speed_vec_t speed_src_out,
  output logic [ENTRIES-1:0] torque_ext_out,
  output logic [ENTRIES-1:0] accel_time_pot_out,
  output logic [ENTRIES-1:0] decel_time_pot_out
);
  import ssel_pkg::*;

  ssel_state_t state_reg;
  ssel_state_t state_next;

  ssel_speed_vec_t map_speed;
  logic [ENTRIES-1:0] map_torque;
  logic [ENTRIES-1:0] map_accel;
  logic [ENTRIES-1:0] map_decel;
  logic signed [SPD_W-1:0] mon_abs;
  logic signed [SPD_W-1:0] mon_neg;
  logic [`SSEL_DW-1:0] status_word;

  // source decode from the active (sampled at reset and on reload_in) speed/torque selection and the live ramp register
  ssel_source_map
  #(
    .ENTRIES(ENTRIES)
  )
  u_map
  (
    .pos_mode_in(pos_mode_in),
    .st_sel_in(state_reg.st_active),
    .ramp_sel_in(state_reg.ramp_src[0]),
    .speed_src_out(map_speed),
    .torque_ext_out(map_torque),
    .accel_pot_out(map_accel),
    .decel_pot_out(map_decel)
  );

  assign mon_neg = SPD_W'(-speed_mon_in);
  assign mon_abs = speed_mon_in[SPD_W-1] ? mon_neg : speed_mon_in;

  always_comb
  begin
    status_word = '0;
    status_word[`SSEL_STAT_ACT_MSB:`SSEL_STAT_ACT_LSB] = state_reg.st_active;
    status_word[`SSEL_STAT_POS_BIT] = pos_mode_in;
    status_word[`SSEL_STAT_PEND_BIT] = (state_reg.st_stored[1:0] != state_reg.st_active);
  end

  always_comb
  begin
    state_next = state_reg;
    state_next.rdata = '0;

    // register writes, out-of-range codes dropped
    if (wr_in)
    begin
      if (addr_in == `SSEL_ADDR_SPD_DISP)
      begin
        if (wdata_in <= `SSEL_MAX_SPD_DISP)
          state_next.spd_disp = wdata_in;
      end
      else if (addr_in == `SSEL_ADDR_SET_VIEW)
      begin
        if (wdata_in <= `SSEL_MAX_VIEW)
          state_next.set_view = wdata_in;
      end
      else if (addr_in == `SSEL_ADDR_ST_SRC)
      begin
        if (wdata_in <= `SSEL_MAX_ST_SRC)
          state_next.st_stored = wdata_in;
      end
      else if (addr_in == `SSEL_ADDR_RAMP_SRC)
      begin
        if (wdata_in <= `SSEL_MAX_RAMP_SRC)
          state_next.ramp_src = wdata_in;
      end
      else if (addr_in == `SSEL_ADDR_PANEL_VIEW)
      begin
        if (wdata_in <= `SSEL_MAX_VIEW)
          state_next.panel_view = wdata_in;
      end
    end

    // register reads, data in the following cycle only
    if (rd_in)
    begin
      if (addr_in == `SSEL_ADDR_SPD_DISP)
        state_next.rdata = state_reg.spd_disp;
      else if (addr_in == `SSEL_ADDR_SET_VIEW)
        state_next.rdata = state_reg.set_view;
      else if (addr_in == `SSEL_ADDR_ST_SRC)
        state_next.rdata = state_reg.st_stored;
      else if (addr_in == `SSEL_ADDR_RAMP_SRC)
        state_next.rdata = state_reg.ramp_src;
      else if (addr_in == `SSEL_ADDR_PANEL_VIEW)
        state_next.rdata = state_reg.panel_view;
      else if (addr_in == `SSEL_ADDR_STATUS)
        state_next.rdata = status_word;
      else
        state_next.rdata = '0;
    end

    // speed/torque selection is latched in the first cycle after reset and on reload_in
    case (state_reg.phase)
      SSEL_PH_SAMPLE:
      begin
        state_next.st_active = state_reg.st_stored[1:0];
        state_next.phase = SSEL_PH_RUN;
      end
      SSEL_PH_RUN:
      begin
        if (reload_in)
          state_next.phase = SSEL_PH_SAMPLE;
      end
      default:
      begin
        state_next.phase = SSEL_PH_SAMPLE;
      end
    endcase

    // registered source map; ramp pots only in speed mode
    state_next.speed_src = map_speed;
    state_next.torque_ext = map_torque;
    state_next.accel_pot = map_accel;
    state_next.decel_pot = map_decel;

    // speed monitor formatting for the data setter
    case (state_reg.spd_disp)
      `SSEL_DISP_ABS:
      begin
        state_next.disp_value = mon_abs;
        state_next.disp_neg = 1'b0;
        state_next.disp_sign_on = 1'b0;
      end
      `SSEL_DISP_MINUS:
      begin
        state_next.disp_value = mon_neg;
        state_next.disp_neg = mon_neg[SPD_W-1];
        state_next.disp_sign_on = 1'b1;
      end
      default:
      begin
        state_next.disp_value = speed_mon_in;
        state_next.disp_neg = speed_mon_in[SPD_W-1];
        state_next.disp_sign_on = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      state_reg.phase <= SSEL_PH_SAMPLE;
      state_reg.spd_disp <= `SSEL_RST_SPD_DISP;
      state_reg.set_view <= `SSEL_RST_SET_VIEW;
      state_reg.st_stored <= `SSEL_RST_ST_SRC;
      state_reg.ramp_src <= `SSEL_RST_RAMP_SRC;
      state_reg.panel_view <= `SSEL_RST_PANEL_VIEW;
      state_reg.st_active <= 2'(`SSEL_RST_ST_SRC);
      state_reg.speed_src <= '0;
      state_reg.torque_ext <= '0;
      state_reg.accel_pot <= '0;
      state_reg.decel_pot <= '0;
      state_reg.disp_value <= '0;
      state_reg.disp_neg <= 1'b0;
      state_reg.disp_sign_on <= 1'b0;
      state_reg.rdata <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign rdata_out = state_reg.rdata;
  assign disp_value_out = state_reg.disp_value;
  assign disp_neg_out = state_reg.disp_neg;
  assign disp_sign_on_out = state_reg.disp_sign_on;
  assign setter_view_out = state_reg.set_view;
  assign panel_view_out = state_reg.panel_view;
  assign st_active_out = state_reg.st_active;
  assign speed_src_out = state_reg.speed_src;
  assign torque_ext_out = state_reg.torque_ext;
  assign accel_time_pot_out = state_reg.accel_pot;
  assign decel_time_pot_out = state_reg.decel_pot;

endmodule
`default_nettype wire

// ---- ssel_far_model.sv ----
// far-side model: speed monitor source and control mode selector
`timescale 1ns/1ps
`default_nettype none

module ssel_far_model (
  input wire logic [15:0] spd_set_in,
  input wire logic pos_set_in,
  output logic signed [15:0] speed_mon_out,
  output logic pos_mode_out
);
  assign speed_mon_out = spd_set_in;
  assign pos_mode_out = pos_set_in;
endmodule

`default_nettype wire

// ---- ssel_top_sva.sv ----
// assertion checker for the setting source selector
`timescale 1ns/1ps
`default_nettype none

module ssel_chk
import ssel_pkg::*;
#(
  parameter int ENTRIES = 16,
  parameter int SPD_W = 16
)
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [11:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic reload_in,
  input wire logic pos_mode_in,
  input wire logic signed [SPD_W-1:0] speed_mon_in,
  input wire logic signed [SPD_W-1:0] disp_value_out,
  input wire logic disp_sign_on_out,
  input wire logic [7:0] setter_view_out,
  input wire logic [7:0] panel_view_out,
  input wire logic [1:0] st_active_out,
  input wire ssel_speed_vec_t speed_src_out,
  input wire logic [ENTRIES-1:0] torque_ext_out,
  input wire logic [ENTRIES-1:0] accel_time_pot_out,
  input wire logic [ENTRIES-1:0] decel_time_pot_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  set_view_a:
  assert property (wr_in && addr_in == 12'h870 && wdata_in <= 8'h05 |=> setter_view_out == $past(wdata_in))
  else $error("setter view not taken");
  panel_view_a:
  assert property (wr_in && addr_in == 12'h874 && wdata_in <= 8'h05 |=> panel_view_out == $past(wdata_in))
  else $error("panel view not taken");
  view_hold_a:
  assert property (wr_in && addr_in == 12'h874 && wdata_in > 8'h05 |=> $stable(panel_view_out))
  else $error("bad view code stored");
  disp_abs_a:
  assert property ($past(rst_b_in) && !disp_sign_on_out |->
    disp_value_out == ($past(speed_mon_in) < 0 ? -$past(speed_mon_in) : $past(speed_mon_in)))
  else $error("absolute display wrong");
  torque_src_a:
  assert property ($past(rst_b_in) |-> torque_ext_out == {ENTRIES{$past(st_active_out) == 2'h2}})
  else $error("torque source wrong");
  speed_map_a:
  assert property ($past(rst_b_in) && !$past(pos_mode_in) && $past(st_active_out) == 2'h1 |->
    speed_src_out[0] == 2'h1 && speed_src_out[1] == 2'h2)
  else $error("speed source map wrong");
  pos_digital_a:
  assert property ($past(rst_b_in) && $past(pos_mode_in) |->
    speed_src_out == '0 && accel_time_pot_out == '0 && decel_time_pot_out == '0)
  else $error("position mode not digital");
  st_hold_a:
  assert property ($past(rst_b_in) && $past(rst_b_in, 2) && !$past(reload_in) && !$past(reload_in, 2) |->
    $stable(st_active_out))
  else $error("source changed without power-up");
endmodule

bind ssel_top ssel_chk #(.ENTRIES(ENTRIES), .SPD_W(SPD_W)) ssel_chk_inst (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .reload_in(reload_in), .pos_mode_in(pos_mode_in), .speed_mon_in(speed_mon_in),
  .disp_value_out(disp_value_out), .disp_sign_on_out(disp_sign_on_out), .setter_view_out(setter_view_out),
  .panel_view_out(panel_view_out), .st_active_out(st_active_out), .speed_src_out(speed_src_out),
  .torque_ext_out(torque_ext_out), .accel_time_pot_out(accel_time_pot_out),
  .decel_time_pot_out(decel_time_pot_out)
);

`default_nettype wire

// ---- ssel_top_tb.sv ----
// self-checking bench for the setting source selector
`timescale 1ns/1ps
`default_nettype none

module ssel_top_tb;
  import ssel_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [11:0] addr_in = 12'h000;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic reload_in = 1'b0;
  logic [15:0] spd_set = 16'h0000;
  logic pos_set = 1'b0;
  logic [7:0] rdata_out, setter_view_out, panel_view_out;
  logic signed [15:0] speed_mon_in, disp_value_out;
  logic disp_neg_out, disp_sign_on_out, pos_mode_in;
  logic [1:0] st_active_out;
  ssel_speed_vec_t speed_src_out;
  logic [15:0] torque_ext_out, accel_time_pot_out, decel_time_pot_out;
  int num_errors = 0;
  int checks = 0;
  int seed = 62;
  int v, e, stm, act;
  int rst_val [5] = '{0, 0, 1, 1, 0};
  logic [11:0] adr [5] = '{12'h1E0, 12'h870, 12'h871, 12'h872, 12'h874};

  always #4 clk_in = ~clk_in;

  ssel_far_model ssel_far_model_inst (.spd_set_in(spd_set), .pos_set_in(pos_set),
    .speed_mon_out(speed_mon_in), .pos_mode_out(pos_mode_in));

  ssel_top ssel_top_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pos_mode_in(pos_mode_in), .reload_in(reload_in),
    .speed_mon_in(speed_mon_in), .disp_value_out(disp_value_out), .disp_neg_out(disp_neg_out),
    .disp_sign_on_out(disp_sign_on_out), .setter_view_out(setter_view_out), .panel_view_out(panel_view_out),
    .st_active_out(st_active_out), .speed_src_out(speed_src_out), .torque_ext_out(torque_ext_out),
    .accel_time_pot_out(accel_time_pot_out), .decel_time_pot_out(decel_time_pot_out));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input int x);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    cmp(rdata_out, x);
  endtask

  task automatic chk_src(input int p, input int s, input int r);
    cmp(st_active_out, s);
    cmp(speed_src_out, (!p && s == 1) ? 9 : 0);
    cmp(torque_ext_out, (s == 2) ? 16'hFFFF : 0);
    cmp(accel_time_pot_out, (!p && r == 1) ? 3 : 0);
    cmp(decel_time_pot_out, (!p && r == 1) ? 3 : 0);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #100000;
    num_errors++;
    close_out();
  end

  initial
  begin
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 5; i++)
      rd(adr[i], rst_val[i]);
    rd(12'h100, 0);
    $display("reset values done");
    for (int c = 0; c < 3; c++)
    begin
      wr(12'h1E0, c[7:0]);
      v = $random(seed) % 30000;
      spd_set <= v[15:0];
      e = (c == 1 && v < 0 || c == 2) ? -v : v;
      repeat (2) @(posedge clk_in);
      #1;
      cmp(disp_value_out, e);
      cmp(disp_sign_on_out, c != 1);
      cmp(disp_neg_out, e < 0);
    end
    wr(12'h1E0, 8'h03);
    rd(12'h1E0, 2);
    wr(12'h872, 8'h02);
    rd(12'h872, 1);
    $display("display test done");
    for (int k = 0; k < 7; k++)
    begin
      v = (k == 6) ? 6 + ($random(seed) & 15) : k;
      e = (k == 6) ? 5 : k;
      wr(12'h870, v[7:0]);
      wr(12'h874, v[7:0]);
      #1;
      cmp(setter_view_out, e);
      cmp(panel_view_out, e);
      rd(12'h874, e);
    end
    $display("view test done");
    act = 1;
    stm = 1;
    for (int p = 0; p < 2; p++)
      for (int s = 0; s < 4; s++)
        for (int r = 0; r < 2; r++)
        begin
          pos_set <= p[0];
          wr(12'h872, r[7:0]);
          wr(12'h871, s[7:0]);
          if (s < 3)
            stm = s;
          rd(12'h871, stm);
          rd(12'h880, (stm != act ? 8 : 0) + 4 * p + act);
          cmp(st_active_out, act);
          @(posedge clk_in);
          reload_in <= 1'b1;
          @(posedge clk_in);
          reload_in <= 1'b0;
          repeat (3) @(posedge clk_in);
          #1;
          act = stm;
          chk_src(p, act, r);
        end
    $display("source test done");
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    chk_src(1, 1, 1);
    rd(12'h871, 1);
    $display("second reset done");
    close_out();
  end
endmodule

`default_nettype wire
